// ---- logic/tph_top.sv ----
`timescale 1ns/1ps
`include "tph_defs.svh"

module tph_top #(
  parameter int DEPTH = `TPH_BUF_DEPTH
) (
  input  wire logic                core_clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                tx_bus_enable_i,
  input  wire logic                hs_hdlc_mode_i,
  input  wire logic                tx_bus_payload_indicator_i,
  input  wire logic                tx_bus_clock_i,
  input  wire tph_pkg::tph_octet_t tx_bus_data_byte_i,
  input  wire logic                hdlc_tx_byte_clock_i,
  input  wire tph_pkg::tph_octet_t hdlc_tx_byte_in_i,
  input  wire logic                hdlc_octet_ready_i,
  output tph_pkg::tph_octet_t      tx_bus_byte_o,
  output logic                     tx_bus_byte_payload_o,
  output logic                     tx_bus_byte_valid_o,
  output tph_pkg::tph_octet_t      hdlc_octet_o,
  output logic                     hdlc_octet_valid_o,
  output logic                     hdlc_in_frame_o,
  output logic                     hdlc_overrun_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic                                pin1;
    logic                                pin2;
    logic                                bclk1;
    logic                                bclk2;
    logic                                bclk_d;
    tph_pkg::tph_octet_t                 bdat1;
    tph_pkg::tph_octet_t                 bdat2;
    logic                                hclk1;
    logic                                hclk2;
    logic                                hclk_d;
    tph_pkg::tph_octet_t                 hdat1;
    tph_pkg::tph_octet_t                 hdat2;
    tph_pkg::tph_octet_t                 bus_byte;
    logic                                bus_payload;
    logic                                bus_valid;
    logic [DEPTH-1:0][`TPH_BYTE_W-1:0]   mem;
    logic [PW-1:0]                       wr;
    logic [PW-1:0]                       rd;
    logic [CW-1:0]                       cnt;
    logic                                in_frame;
    logic                                esc_pend;
    tph_pkg::tph_octet_t                 pend;
    tph_pkg::tph_octet_t                 octet;
    logic                                out_valid;
    logic                                overrun;
  } tph_state_s;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    if (p == PW'(DEPTH - 1)) begin
      return '0;
    end
    return PW'(p + PW'(1));
  endfunction

  function automatic logic needs_esc(input tph_pkg::tph_octet_t d);
    return (d == `TPH_FLAG) || (d == `TPH_ESC);
  endfunction

  logic        rst_s1_ff;
  logic        rst_s2_ff;
  tph_state_s  s_ff;
  tph_state_s  nxt_s;
  logic        bus_fall;
  logic        hclk_rise;
  logic        hdlc_active;
  logic        hdlc_send_message_cmd;
  logic        push_req;
  logic        push;
  logic        pop;
  logic        load;
  tph_pkg::tph_octet_t head;

  // reset released through two flops so every state flop leaves reset together
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end

  always_comb begin
    nxt_s = s_ff;
    nxt_s.pin1   = tx_bus_payload_indicator_i;
    nxt_s.pin2   = s_ff.pin1;
    nxt_s.bclk1  = tx_bus_clock_i;
    nxt_s.bclk2  = s_ff.bclk1;
    nxt_s.bclk_d = s_ff.bclk2;
    nxt_s.bdat1  = tx_bus_data_byte_i;
    nxt_s.bdat2  = s_ff.bdat1;
    nxt_s.hclk1  = hdlc_tx_byte_clock_i;
    nxt_s.hclk2  = s_ff.hclk1;
    nxt_s.hclk_d = s_ff.hclk2;
    nxt_s.hdat1  = hdlc_tx_byte_in_i;
    nxt_s.hdat2  = s_ff.hdat1;

    bus_fall    = s_ff.bclk_d & ~s_ff.bclk2;
    hclk_rise   = ~s_ff.hclk_d & s_ff.hclk2;
    // pin meaning follows the bus enable
    hdlc_active = !tx_bus_enable_i && hs_hdlc_mode_i;
    hdlc_send_message_cmd = hdlc_active && s_ff.pin2;

    nxt_s.bus_valid = 1'b0;
    if (tx_bus_enable_i && bus_fall) begin
      nxt_s.bus_valid   = 1'b1;
      nxt_s.bus_byte    = s_ff.bdat2;
      nxt_s.bus_payload = s_ff.pin2;
    end

    push_req = hdlc_send_message_cmd && hclk_rise;
    load     = !s_ff.out_valid || hdlc_octet_ready_i;
    pop      = 1'b0;
    head     = s_ff.mem[s_ff.rd];

    if (load) begin
      nxt_s.out_valid = 1'b1;
      if (s_ff.esc_pend) begin
        nxt_s.octet    = s_ff.pend;
        nxt_s.esc_pend = 1'b0;
      end else if (s_ff.cnt != '0) begin
        if (!s_ff.in_frame) begin
          // opening flag before the first byte of a frame
          nxt_s.octet    = `TPH_FLAG;
          nxt_s.in_frame = 1'b1;
        end else begin
          pop = 1'b1;
          if (needs_esc(head)) begin
            // octet stuffing keeps flags unique inside the frame
            nxt_s.octet    = `TPH_ESC;
            nxt_s.esc_pend = 1'b1;
            nxt_s.pend     = head ^ `TPH_ESC_XOR;
          end else begin
            nxt_s.octet = head;
          end
        end
      end else begin
        nxt_s.octet = `TPH_FLAG;
        if (!hdlc_send_message_cmd) begin
          nxt_s.in_frame = 1'b0;
        end
      end
    end

    // byte source has no stall, so a full buffer can only be reported
    push = push_req && ((s_ff.cnt != CW'(DEPTH)) || pop);
    if (push_req && !push) begin
      nxt_s.overrun = 1'b1;
    end
    if (push) begin
      nxt_s.mem[s_ff.wr] = s_ff.hdat2;
      nxt_s.wr = ptr_inc(s_ff.wr);
    end
    if (pop) begin
      nxt_s.rd = ptr_inc(s_ff.rd);
    end
    nxt_s.cnt = CW'(s_ff.cnt + CW'(push) - CW'(pop));
  end

  always_ff @(posedge core_clk_i or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tx_bus_byte_o         = s_ff.bus_byte;
  assign tx_bus_byte_payload_o = s_ff.bus_payload;
  assign tx_bus_byte_valid_o   = s_ff.bus_valid;
  assign hdlc_octet_o          = s_ff.octet;
  assign hdlc_octet_valid_o    = s_ff.out_valid;
  assign hdlc_in_frame_o       = s_ff.in_frame;
  assign hdlc_overrun_o        = s_ff.overrun;

  property p_bus_mode_no_hdlc;
    @(posedge core_clk_i) disable iff (!rst_s2_ff)
      tx_bus_enable_i |-> !push;
  endproperty
  a_bus_mode_no_hdlc: assert property (p_bus_mode_no_hdlc) else $error("byte latched in bus mode");

  property p_no_bus_byte_when_off;
    @(posedge core_clk_i) disable iff (!rst_s2_ff)
      (!tx_bus_enable_i && $past(!tx_bus_enable_i)) |-> !tx_bus_byte_valid_o;
  endproperty
  a_no_bus_byte_when_off: assert property (p_no_bus_byte_when_off) else $error("bus byte while off");

  property p_fall_sample;
    @(posedge core_clk_i) disable iff (!rst_s2_ff)
      (tx_bus_enable_i && bus_fall) |=>
        tx_bus_byte_valid_o && (tx_bus_byte_payload_o == $past(s_ff.pin2))
        && (tx_bus_byte_o == $past(s_ff.bdat2)) ##1 !tx_bus_byte_valid_o;
  endproperty
  a_fall_sample: assert property (p_fall_sample) else $error("bus byte not sampled at fall");

  property p_latch_on_rise;
    @(posedge core_clk_i) disable iff (!rst_s2_ff)
      (push && s_ff.cnt == '0) |=> (s_ff.cnt == CW'(1)) && (s_ff.mem[s_ff.rd] == $past(s_ff.hdat2));
  endproperty
  a_latch_on_rise: assert property (p_latch_on_rise) else $error("hdlc byte not latched");

  property p_cmd_push;
    @(posedge core_clk_i) disable iff (!rst_s2_ff)
      (hdlc_send_message_cmd && hclk_rise) |-> (push or (1'b1 ##1 hdlc_overrun_o));
  endproperty
  a_cmd_push: assert property (p_cmd_push) else $error("byte lost without overrun");

  property p_flag_outside_frame;
    @(posedge core_clk_i) disable iff (!rst_s2_ff)
      (load && !s_ff.in_frame && !s_ff.esc_pend) |=> hdlc_octet_o == `TPH_FLAG;
  endproperty
  a_flag_outside_frame: assert property (p_flag_outside_frame) else $error("data outside frame");

  property p_stall_hold;
    @(posedge core_clk_i) disable iff (!rst_s2_ff)
      (hdlc_octet_valid_o && !hdlc_octet_ready_i) |=> $stable(hdlc_octet_o) && hdlc_octet_valid_o;
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("octet changed under stall");

  property p_idle_flags;
    @(posedge core_clk_i) disable iff (!rst_s2_ff)
      (!hdlc_send_message_cmd && s_ff.cnt == '0 && !s_ff.esc_pend && load)
        |=> (hdlc_octet_o == `TPH_FLAG) ##1 !s_ff.in_frame;
  endproperty
  a_idle_flags: assert property (p_idle_flags) else $error("non-flag while idle");

  property p_ignore_bytes;
    @(posedge core_clk_i) disable iff (!rst_s2_ff)
      !hdlc_send_message_cmd |-> !push;
  endproperty
  a_ignore_bytes: assert property (p_ignore_bytes) else $error("byte taken while cmd low");

  c_push:    cover property (@(posedge core_clk_i) disable iff (!rst_s2_ff) push ##[1:20] pop);
  c_toh:     cover property (@(posedge core_clk_i) disable iff (!rst_s2_ff)
                             tx_bus_byte_valid_o && !tx_bus_byte_payload_o);
  c_escape:  cover property (@(posedge core_clk_i) disable iff (!rst_s2_ff)
                             hdlc_octet_valid_o && hdlc_octet_o == `TPH_ESC);
  c_overrun: cover property (@(posedge core_clk_i) disable iff (!rst_s2_ff) $rose(hdlc_overrun_o));

endmodule

// ---- shared/tph_defs.svh ----
`ifndef TPH_DEFS_SVH
`define TPH_DEFS_SVH
// Operation
// - The shared pin is a payload indicator while the telecom bus is enabled and an HDLC send-message command when the bus is disabled and HS HDLC mode is selected.
// - The payload indicator and bus byte are sampled on the falling edge of the telecom bus clock.
// - While the send-message command is high, each rising edge of the HDLC byte clock latches the HDLC byte, or sets the overrun flag if the buffer is full
//   and no byte is read out of it in the same cycle.
// - Every latched byte is sent inside an HDLC frame on the octet stream toward the frame generator.
// - While the send-message command is low, byte inputs are ignored and only flag octets are sent once the buffered bytes have drained.

`define TPH_FLAG     8'h7E
`define TPH_ESC      8'h7D
`define TPH_ESC_XOR  8'h20
`define TPH_BYTE_W   8
`define TPH_BUF_DEPTH 2

`endif

// ---- shared/tph_pkg.sv ----
package tph_pkg;
  typedef logic [7:0] tph_octet_t;
endpackage

// ---- sim/tb_tph_top.sv ----
`timescale 1ns/1ps
`include "tph_defs.svh"
module tb_tph_top;
  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  logic                bus_en = 1'b1;
  logic                hs = 1'b0;
  logic                rdy = 1'b1;
  logic                stall = 1'b0;
  logic                pin, bclk, hclk, bpl, bv, hv, inf, ovr;
  tph_pkg::tph_octet_t bd, hd, bo, ho, b;
  logic                p;
  int                  mismatches = 0;
  int                  samples_checked = 0;
  logic [8:0]          exp_bus[$];
  logic [7:0]          exp_oct[$];

  initial forever #4 clk = ~clk;

  tph_upstream i_up (.clk_i(clk), .pin_o(pin), .bclk_o(bclk), .bdata_o(bd),
    .hclk_o(hclk), .hdata_o(hd));
  tph_top i_dut (.core_clk_i(clk), .rst_n_i(rst_n), .tx_bus_enable_i(bus_en),
    .hs_hdlc_mode_i(hs), .tx_bus_payload_indicator_i(pin), .tx_bus_clock_i(bclk),
    .tx_bus_data_byte_i(bd), .hdlc_tx_byte_clock_i(hclk), .hdlc_tx_byte_in_i(hd),
    .hdlc_octet_ready_i(rdy), .tx_bus_byte_o(bo), .tx_bus_byte_payload_o(bpl),
    .tx_bus_byte_valid_o(bv), .hdlc_octet_o(ho), .hdlc_octet_valid_o(hv),
    .hdlc_in_frame_o(inf), .hdlc_overrun_o(ovr));

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // receiver stalls at random to exercise the two-entry buffer
  always @(posedge clk) rdy <= !stall && (($urandom % 4) != 0);

  always @(posedge clk) begin
    if (bv === 1'b1) chk({bpl, bo}, exp_bus.pop_front());
    if (hv === 1'b1 && rdy && ho !== 8'h7E) begin
      chk(9'(ho), 9'(exp_oct.size() ? exp_oct.pop_front() : 8'h7E));
      chk(9'(inf), 9'h001);
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    conclude();
  end

  initial begin
    void'($urandom(3890));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    for (int i = 0; i < 12; i++) begin
      b = 8'($urandom);
      p = (i % 4) != 0;
      exp_bus.push_back({p, b});
      fork
        i_up.bus_byte(b, p);
        i_up.hdlc_byte(8'($urandom));  // ignored while bus on
      join
    end
    bus_en <= 1'b0;
    hs     <= 1'b1;
    i_up.set_pin(1'b0);
    for (int i = 0; i < 4; i++) i_up.hdlc_byte(8'($urandom));
    i_up.set_pin(1'b1);
    for (int i = 0; i < 16; i++) begin
      b = (i == 0) ? 8'h7E : (i == 1) ? 8'h7D : 8'($urandom);
      if (b == 8'h7E || b == 8'h7D) begin
        exp_oct.push_back(8'h7D);
        exp_oct.push_back(b ^ 8'h20);
      end else exp_oct.push_back(b);
      i_up.hdlc_byte(b);
    end
    i_up.set_pin(1'b0);
    for (int k = 0; k < 2000 && (exp_oct.size() || inf !== 1'b0); k++) @(posedge clk);
    chk(9'(exp_oct.size() + exp_bus.size()), 9'h000);
    chk(9'(inf), 9'h000);
    chk(9'(ovr), 9'h000);
    // stalled receiver: one byte more than the buffer holds must be flagged
    stall <= 1'b1;
    i_up.set_pin(1'b1);
    for (int i = 0; i < `TPH_BUF_DEPTH + 1; i++) i_up.hdlc_byte(8'($urandom));
    chk(9'(ovr), 9'h001);
    // mid-run reset clears the sticky flag and the buffer
    rst_n <= 1'b0;
    i_up.set_pin(1'b0);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    stall <= 1'b0;
    repeat (20) @(posedge clk);
    chk(9'(ovr), 9'h000);
    chk(9'(inf), 9'h000);
    conclude();
  end
endmodule

// ---- sim/tph_upstream.sv ----
`timescale 1ns/1ps
module tph_upstream (
  input  wire logic           clk_i,
  output logic                pin_o,
  output logic                bclk_o,
  output tph_pkg::tph_octet_t bdata_o,
  output logic                hclk_o,
  output tph_pkg::tph_octet_t hdata_o
);
  initial begin
    pin_o   = 1'b0;  // low until a mode uses it
    bclk_o  = 1'b1;
    bdata_o = 8'h00;
    hclk_o  = 1'b0;
    hdata_o = 8'h00;
  end
  task automatic wait_c(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // bus clock idles high between bytes, one fall per byte
  // back-to-back calls give a steady 160 ns bus clock
  task automatic bus_byte(input tph_pkg::tph_octet_t d, input logic pl);
    bdata_o <= d;
    pin_o   <= pl;
    wait_c(5);
    bclk_o <= 1'b0;
    wait_c(10);
    bclk_o  <= 1'b1;
    bdata_o <= ~d;  // released lines show no stale byte
    wait_c(5);
  endtask
  task automatic set_pin(input logic v);
    pin_o <= v;
    wait_c(1);
  endtask
  task automatic hdlc_byte(input tph_pkg::tph_octet_t d);
    hdata_o <= d;
    wait_c(5);
    hclk_o <= 1'b1;
    wait_c(10);
    hclk_o  <= 1'b0;
    hdata_o <= ~d;
    wait_c(5);
  endtask
endmodule
